// File: common/dps_pkg.sv
package dps_pkg;
  // Pin usage per general-purpose buffer
  typedef enum logic [1:0] {
    DPS_IO_INPUT  = 2'h0,
    DPS_IO_OUTPUT = 2'h1,
    DPS_IO_TRI    = 2'h2,
    DPS_IO_BIDIR  = 2'h3
  } dps_io_mode_t;

  // Multifunction pin indices in the shared user I/O vectors
  localparam int unsigned DPS_PIN_DIAG_CK = 0;
  localparam int unsigned DPS_PIN_PROBE1 = 1;
  localparam int unsigned DPS_PIN_PROBE2 = 2;
  localparam int unsigned DPS_PIN_SIN   = 3;
  localparam int unsigned DPS_PIN_SOUT  = 4;
  localparam int unsigned DPS_PIN_CLK1  = 5;
  localparam int unsigned DPS_PIN_CLK2  = 6;
  localparam int unsigned DPS_NUM_PINS  = 7;

  // Node selector width and reset values
  localparam int unsigned DPS_SEL_W     = 4;
  localparam logic [3:0]  DPS_SEL_RST   = 4'h0;
  localparam logic        DPS_LOCK_RST  = 1'b0;

  // Diagnostic shift register: two selectors
  localparam int unsigned DPS_SHIFT_W   = 2 * DPS_SEL_W;
endpackage : dps_pkg

// File: logic/dps_pin_buf.sv
// One general-purpose pin buffer: input, output, three-state or bidirectional
module dps_pin_buf
  import dps_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  dps_pkg::dps_io_mode_t mode,
  input  wire logic         out_val,
  input  wire logic         out_en,
  input  wire logic         pad_i,
  output logic              pad_o,
  output logic              pad_oe,
  output logic              in_val
);
  logic drv_d;
  logic pad_o_q;
  logic pad_oe_q;
  logic in_q;

  // Output mode always drives; tri and bidir follow the user enable
  assign drv_d = (mode == DPS_IO_OUTPUT) ||
                 ((mode == DPS_IO_TRI || mode == DPS_IO_BIDIR) && out_en);
  assign pad_o  = pad_o_q;
  assign pad_oe = pad_oe_q;
  assign in_val = in_q;

  // Registered pad drive and capture
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pad_o_q  <= 1'b0;
      pad_oe_q <= 1'b0;
      in_q     <= 1'b0;
    end
    else
    begin
      pad_o_q  <= out_val;
      pad_oe_q <= drv_d;
      // Pure output never feeds back its own pad
      in_q     <= (mode == DPS_IO_OUTPUT) ? 1'b0 : pad_i;
    end
  end
endmodule : dps_pin_buf

// File: logic/dps_probe_sel.sv
// How it works
// - Mode high makes diag clock, serial input and, while unlocked, both probes diagnostic pins, mode low makes them user I/O.
// - The serial output echoes the shifted selector bits in diagnostic mode until locked, then drives low, and is user I/O otherwise.
// - Each probe pin shows the live value of a selected internal node, both usable at once.
// - A one-way lock permanently disables probing until the device is cleared.
// - After debugging each probe pin behaves as an ordinary user I/O.
// - The diag clock times probe and programming shifts and is honoured only in diagnostic mode.
// - Serial data for probe control and programming is accepted only in diagnostic mode.
// - Every general pin can be input, output, three-state or bidirectional.
// - Each array clock pin feeds a buffered clock net, or serves as user I/O.
module dps_probe_sel
  import dps_pkg::*;
#(
  parameter int unsigned NODE_W = 16
)
(
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  mode_sel,
  input  wire logic                  probe_lock_req,
  input  wire logic [NODE_W-1:0]     node_vals,
  input  dps_pkg::dps_io_mode_t      io_mode [DPS_NUM_PINS],
  input  wire logic [DPS_NUM_PINS-1:0] user_out,
  input  wire logic [DPS_NUM_PINS-1:0] user_oe,
  input  wire logic [DPS_NUM_PINS-1:0] pad_i,
  input  wire logic                  clk1_use_net,
  input  wire logic                  clk2_use_net,
  output logic [DPS_NUM_PINS-1:0]    pad_o,
  output logic [DPS_NUM_PINS-1:0]    pad_oe,
  output logic [DPS_NUM_PINS-1:0]    user_in,
  output logic                       array_clock_first_net,
  output logic                       array_clock_second_net,
  output logic                       prog_bit_valid,
  output logic                       prog_bit,
  output logic                       probe_locked
);
  logic [DPS_NUM_PINS-1:0] bo;
  logic [DPS_NUM_PINS-1:0] boe;
  logic [DPS_NUM_PINS-1:0] bin;
  logic [DPS_NUM_PINS-1:0] diag_pin;
  logic                    diag_active;
  logic                    probe_en;
  logic                    dck_edge;
  logic                    sin_bit;
  logic                    sel_load;
  logic                    dck_q;
  logic                    dck_d;
  logic                    lock_q;
  logic                    lock_d;
  logic [DPS_SHIFT_W-1:0]  shift_q;
  logic [DPS_SHIFT_W-1:0]  shift_d;
  logic [DPS_SEL_W-1:0]    sel1_q;
  logic [DPS_SEL_W-1:0]    sel1_d;
  logic [DPS_SEL_W-1:0]    sel2_q;
  logic [DPS_SEL_W-1:0]    sel2_d;
  logic                    p1_q;
  logic                    p1_d;
  logic                    p2_q;
  logic                    p2_d;
  logic                    so_q;
  logic                    so_d;
  logic                    pbv_q;
  logic                    pbv_d;
  logic                    pb_q;
  logic                    pb_d;
  logic                    ck1_q;
  logic                    ck2_q;
  logic [DPS_SEL_W:0]      cnt_q;
  logic [DPS_SEL_W:0]      cnt_d;

  // Mode decides which multifunction pins leave the user's hands
  assign diag_active = mode_sel;
  // Lock withdraws the probes even with mode high, so nodes stay hidden
  assign probe_en    = diag_active && !lock_q;
  assign diag_pin[DPS_PIN_DIAG_CK] = diag_active;
  assign diag_pin[DPS_PIN_SIN]    = diag_active;
  assign diag_pin[DPS_PIN_PROBE1] = probe_en;
  assign diag_pin[DPS_PIN_PROBE2] = probe_en;
  assign diag_pin[DPS_PIN_SOUT]   = diag_active;
  assign diag_pin[DPS_PIN_CLK1]   = clk1_use_net;
  assign diag_pin[DPS_PIN_CLK2]   = clk2_use_net;

  // Diag clock and serial data seen only while diagnostic
  // Edge detector idles low like the pin, so reset makes no false edge
  assign dck_d    = diag_active ? bin[DPS_PIN_DIAG_CK] : 1'b0;
  assign dck_edge = diag_active && dck_d && !dck_q;
  assign sin_bit  = bin[DPS_PIN_SIN];

  // Selector shifting: first DPS_SHIFT_W bits load both node selectors
  assign shift_d = dck_edge ? {shift_q[DPS_SHIFT_W-2:0], sin_bit}
                            : shift_q;
  // Counter stops at the header length; later edges are programming bits
  assign cnt_d   = !diag_active ? '0 :
                   (dck_edge && cnt_q != (DPS_SEL_W+1)'(DPS_SHIFT_W))
                   ? cnt_q + 1'b1 : cnt_q;
  assign sel_load = dck_edge &&
                    cnt_q == (DPS_SEL_W+1)'(DPS_SHIFT_W - 1);
  assign sel1_d  = sel_load ? shift_d[DPS_SHIFT_W-1:DPS_SEL_W] : sel1_q;
  assign sel2_d  = sel_load ? shift_d[DPS_SEL_W-1:0] : sel2_q;
  // Bits beyond the selector header are handed on as programming data
  assign pbv_d   = dck_edge &&
                   cnt_q == (DPS_SEL_W+1)'(DPS_SHIFT_W);
  assign pb_d    = pbv_d ? sin_bit : pb_q;

  // Live node values; selectors past NODE_W read as zero
  assign p1_d = (32'(sel1_q) < NODE_W) ? node_vals[sel1_q] : 1'b0;
  assign p2_d = (32'(sel2_q) < NODE_W) ? node_vals[sel2_q] : 1'b0;
  // Serial output echoes the shifted selector; blanked once locked
  assign so_d = lock_q ? 1'b0 : shift_q[DPS_SHIFT_W-1];

  // Lock is one-way: only a device reset, standing for an erase, clears it
  assign lock_d = lock_q | probe_lock_req;

  // Diagnostic state
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      dck_q   <= 1'b0;
      lock_q  <= DPS_LOCK_RST;
      shift_q <= '0;
      cnt_q   <= '0;
      sel1_q  <= DPS_SEL_RST;
      sel2_q  <= DPS_SEL_RST;
      p1_q    <= 1'b0;
      p2_q    <= 1'b0;
      so_q    <= 1'b0;
      pbv_q   <= 1'b0;
      pb_q    <= 1'b0;
    end
    else
    begin
      dck_q   <= dck_d;
      lock_q  <= lock_d;
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
      sel1_q  <= sel1_d;
      sel2_q  <= sel2_d;
      p1_q    <= p1_d;
      p2_q    <= p2_d;
      so_q    <= so_d;
      pbv_q   <= pbv_d;
      pb_q    <= pb_d;
    end
  end

  // Array clock buffers; one register stage stands in for the net driver
  // A sampled copy: pin edges faster than half of ref_clk are lost
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ck1_q <= 1'b0;
      ck2_q <= 1'b0;
    end
    else
    begin
      ck1_q <= clk1_use_net ? pad_i[DPS_PIN_CLK1] : 1'b0;
      ck2_q <= clk2_use_net ? pad_i[DPS_PIN_CLK2] : 1'b0;
    end
  end

  // Per-pin mux between user path and diagnostic function
  for (genvar i = 0; i < DPS_NUM_PINS; i++)
  begin : g_pin
    logic         f_out;
    logic         f_oe;
    dps_io_mode_t f_mode;
    if (i == DPS_PIN_PROBE1)
    begin : g_p1
      assign f_out = p1_q;
    end
    else if (i == DPS_PIN_PROBE2)
    begin : g_p2
      assign f_out = p2_q;
    end
    else if (i == DPS_PIN_SOUT)
    begin : g_so
      assign f_out = so_q;
    end
    else
    begin : g_in
      assign f_out = 1'b0;
    end
    // Diagnostic outputs drive; diagnostic inputs stay high-Z
    assign f_oe   = (i == DPS_PIN_PROBE1 || i == DPS_PIN_PROBE2 ||
                     i == DPS_PIN_SOUT);
    assign f_mode = diag_pin[i] ? (f_oe ? DPS_IO_OUTPUT : DPS_IO_INPUT)
                                : io_mode[i];

    dps_pin_buf u_buf (
      .ref_clk (ref_clk),
      .rst     (rst),
      .mode    (f_mode),
      .out_val (diag_pin[i] ? f_out : user_out[i]),
      .out_en  (diag_pin[i] ? f_oe : user_oe[i]),
      .pad_i   (pad_i[i]),
      .pad_o   (bo[i]),
      .pad_oe  (boe[i]),
      .in_val  (bin[i])
    );

    // User sees its pin only while it owns it
    logic uin_q;
    always_ff @(posedge ref_clk)
    begin
      if (rst)
        uin_q <= 1'b0;
      else
        uin_q <= diag_pin[i] ? 1'b0 : bin[i];
    end
    assign user_in[i] = uin_q;
  end

  assign pad_o                  = bo;
  assign pad_oe                 = boe;
  assign array_clock_first_net  = ck1_q;
  assign array_clock_second_net = ck2_q;
  assign prog_bit_valid         = pbv_q;
  assign prog_bit               = pb_q;
  assign probe_locked           = lock_q;
endmodule : dps_probe_sel

// File: tb/dps_probe_sel_monitor.sv
module dps_probe_sel_monitor
  import dps_pkg::*;
(
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    mode_sel,
  input wire logic                    probe_lock_req,
  input wire logic                    clk1_use_net,
  input wire logic [DPS_NUM_PINS-1:0] pad_i,
  input wire logic [DPS_NUM_PINS-1:0] pad_o,
  input wire logic [DPS_NUM_PINS-1:0] pad_oe,
  input wire logic [DPS_NUM_PINS-1:0] user_in,
  input wire logic                    array_clock_first_net,
  input wire logic                    prog_bit_valid,
  input wire logic                    probe_locked
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Three cycles cover the pad register and the pin buffer
  sequence s_diag; mode_sel [*3]; endsequence
  sequence s_user; !mode_sel [*4]; endsequence
  property p_lock_set; probe_lock_req |-> ##[1:2] probe_locked; endproperty
  property p_lock_hold; probe_locked |=> probe_locked; endproperty
  property p_diag_in; s_diag |-> user_in[3] == 1'b0 && user_in[0] == 1'b0
    && (probe_locked || user_in[2:1] == 2'h0); endproperty
  property p_probe_oe;
    (mode_sel && !probe_locked) [*3] |-> pad_oe[2:1] == 2'h3;
  endproperty
  property p_lock_sout;
    (mode_sel && probe_locked) [*3] |-> !pad_o[DPS_PIN_SOUT];
  endproperty
  property p_user_quiet; s_user |-> !prog_bit_valid; endproperty
  property p_pulse; prog_bit_valid |=> !prog_bit_valid; endproperty
  property p_clk_net;
    clk1_use_net [*3] |->
      array_clock_first_net == $past(pad_i[DPS_PIN_CLK1]);
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock not set");
  a_lock_hold: assert property (p_lock_hold)
    else $error("lock dropped");
  a_diag_in: assert property (p_diag_in)
    else $error("diag pin leaks to user");
  a_probe_oe: assert property (p_probe_oe)
    else $error("probe not driven");
  a_lock_sout: assert property (p_lock_sout)
    else $error("serial out active when locked");
  a_user_quiet: assert property (p_user_quiet)
    else $error("serial taken in user mode");
  a_pulse: assert property (p_pulse)
    else $error("bit pulse too long");
  a_clk_net: assert property (p_clk_net)
    else $error("clock net mismatch");
endmodule : dps_probe_sel_monitor

// File: tb/dps_prog_model.sv
// Programmer: clock stands low between frames
module dps_prog_model
(
  output logic      diag_ck,
  output logic      ser_in,
  input  wire logic ref_clk
);
  timeunit 1ns / 1ns;
  initial
  begin
    diag_ck = 1'b0;
    ser_in  = 1'b0;
  end
  // Low phase two cycles, high phase three (two on the last bit) so the sampled edge is seen
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge ref_clk);
      ser_in  = b[i];
      diag_ck = 1'b0;
      repeat (2) @(negedge ref_clk);
      diag_ck = 1'b1;
      repeat (2) @(negedge ref_clk);
    end
    diag_ck = 1'b0;
    ser_in  = ~ser_in; // Line driven to the inverse of the last bit: no stale value
  endtask : send
endmodule : dps_prog_model

// File: tb/diag_probe_pin_select_tb.sv
module diag_probe_pin_select_tb;
  import dps_pkg::*;
  timeunit 1ns / 1ns;
  logic ref_clk = 1'b0, rst = 1'b1, mode_sel = 1'b0, lock_req = 1'b0;
  logic c1_net = 1'b0, net1, net2, pv, pb, locked, dck, sin;
  logic [15:0] node_vals = 16'h0;
  logic [6:0] user_out = 7'h0, user_oe = 7'h0, tb_pad = 7'h0, pad_i;
  logic [6:0] pad_o, pad_oe, user_in;
  logic [7:0] rx_q = 8'h0;
  dps_io_mode_t io_mode [DPS_NUM_PINS];
  int error_cnt = 0, check_count = 0;
  always #20 ref_clk = ~ref_clk;
  // Partner owns diag clock and serial input pins
  assign pad_i = {tb_pad[6:4], sin, tb_pad[2:1], dck};
  always @(posedge ref_clk) if (pv) rx_q <= {rx_q[6:0], pb};
  dps_prog_model prog_u (.diag_ck(dck), .ser_in(sin), .ref_clk(ref_clk));
  dps_probe_sel #(.NODE_W(16)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .mode_sel(mode_sel), .probe_lock_req(lock_req), .node_vals(node_vals),
    .io_mode(io_mode), .user_out(user_out), .user_oe(user_oe),
    .pad_i(pad_i), .clk1_use_net(c1_net), .clk2_use_net(c1_net),
    .pad_o(pad_o), .pad_oe(pad_oe), .user_in(user_in),
    .array_clock_first_net(net1), .array_clock_second_net(net2),
    .prog_bit_valid(pv), .prog_bit(pb), .probe_locked(locked));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic t_user;
    user_oe = 7'h7f;
    user_out = 7'h55;
    for (int m = 0; m < 4; m++)
    begin
      foreach (io_mode[i]) io_mode[i] = dps_io_mode_t'(m);
      repeat (3) @(negedge ref_clk);
      chk(pad_oe, (m == 0) ? 16'h0 : 16'h7f);
    end
    chk(pad_o, 16'h55);
    user_oe = 7'h0;
    tb_pad = 7'h2a;
    repeat (3) @(negedge ref_clk);
    chk(user_in, 16'h22);
  endtask : t_user
  // Header picks nodes 5 and 10; other bits disagree to catch a bad pick
  task automatic t_probe;
    mode_sel = 1'b1;
    node_vals = 16'h0420;
    prog_u.send(8'h5a);
    prog_u.send(8'hc3);
    repeat (4) @(negedge ref_clk);
    chk(pad_o[2:1], 16'h3);
    chk(rx_q, 16'hc3);
    node_vals = 16'hfbdf;
    repeat (3) @(negedge ref_clk);
    chk(pad_o[2:1], 16'h0);
  endtask : t_probe
  task automatic t_lock;
    lock_req = 1'b1;
    @(negedge ref_clk);
    lock_req = 1'b0;
    user_oe = 7'h7f;
    user_out = 7'h16;
    repeat (4) @(negedge ref_clk);
    chk({pad_o[4], pad_o[2:1]}, 16'h3);
    mode_sel = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(locked, 16'h1);
  endtask : t_lock
  task automatic t_clk;
    c1_net = 1'b1;
    tb_pad[6:5] = 2'h3;
    repeat (3) @(negedge ref_clk);
    chk({net2, net1}, 16'h3);
    repeat (6) @(negedge ref_clk) tb_pad[5] = ~tb_pad[5];
  endtask : t_clk
  initial
  begin
    foreach (io_mode[i]) io_mode[i] = DPS_IO_BIDIR;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    t_user();
    t_probe();
    t_lock();
    t_clk();
    close_out();
  end
  // Run needs well under 1000 cycles
  initial
  begin
    #400000;
    error_cnt++;
    close_out();
  end
endmodule : diag_probe_pin_select_tb
bind dps_probe_sel dps_probe_sel_monitor mon_u (.ref_clk(ref_clk),
  .rst(rst), .mode_sel(mode_sel), .probe_lock_req(probe_lock_req),
  .clk1_use_net(clk1_use_net), .pad_i(pad_i), .pad_o(pad_o),
  .pad_oe(pad_oe), .user_in(user_in), .prog_bit_valid(prog_bit_valid),
  .array_clock_first_net(array_clock_first_net),
  .probe_locked(probe_locked));
